/* mra_ctl_model.sv */
// controller model driving the command/address link
`timescale 1ns/1ps
module mra_ctl_model #(
  // read latency and strobe skew in clocks
  parameter int RL       = 3,
  parameter int DQSCK_CK = 1
) (
  // command/address link
  input  wire logic       ck,
  output logic            cs_n,
  output logic      [9:0] ca
);
  int cyc    = 0;
  int mrr_at = -100;
  initial begin
    cs_n = 1'b1;
    ca   = 10'h000;
  end
  // link clock count, used to space commands
  always @(posedge ck) begin
    cyc <= cyc + 1;
  end
  // one command, nop from the next rising edge on
  // no array reads or writes are issued
  task automatic cmd(input logic [3:0] code, input logic [7:0] ma, input logic [7:0] wd);
    @(posedge ck);
    while (code == mra_pkg::CMD_MRW && cyc + 1 - mrr_at < RL + DQSCK_CK + 3) begin
      @(posedge ck);
    end
    if (code == mra_pkg::CMD_MRR) begin
      mrr_at = cyc + 1;
    end
    cs_n <= 1'b0;
    ca   <= {ma[7:2], code};
    @(posedge ck);
    cs_n <= 1'b1;
    ca   <= {wd, ma[1:0]};
  endtask
endmodule

/* mra_device.sv */
// mode register read and write logic of the low-power sdram
`timescale 1ns/1ps
module mra_device #(
  parameter int DQ_WIDTH    = 16,
  parameter int RL          = 3,
  parameter int TSI_CYCLES  = mra_pkg::TSI_CYCLES,
  parameter int INIT_CYCLES = mra_pkg::INIT_CYCLES
) (
  // system clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // command/address link
  input  wire logic                  ck,
  input  wire logic                  cs_n,
  input  wire logic [9:0]            ca,
  input  wire logic                  bank_active,
  // data pins
  output logic      [DQ_WIDTH-1:0]   dq_out,
  output logic                       dq_oe_n,
  output logic      [DQ_WIDTH/8-1:0] dqs_out,
  output logic                       dqs_oe_n,
  // sensor and status
  input  wire logic [2:0]            temp_code,
  output logic                       init_busy
);

  localparam int NDQS   = DQ_WIDTH / 8;
  localparam int TW     = $clog2(TSI_CYCLES + 1);
  localparam int LAT_M1 = RL - 1;
  localparam int INIT_M = INIT_CYCLES - 1;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_INIT} mra_state_type;

  // reference domain: sensor sampling
  logic [2:0]    temp_s1;
  logic [2:0]    temp_s2;
  logic [2:0]    temp_word;
  logic [2:0]    next_temp_word;
  logic [TW-1:0] tsi_cnt;
  logic [TW-1:0] next_tsi_cnt;
  logic          temp_tgl;
  logic          next_temp_tgl;

  always_comb begin
    next_tsi_cnt   = tsi_cnt - TW'(1);
    next_temp_word = temp_word;
    next_temp_tgl  = temp_tgl;
    if (tsi_cnt == '0) begin
      next_tsi_cnt   = TW'(TSI_CYCLES - 1);
      next_temp_word = temp_s2;
      next_temp_tgl  = ~temp_tgl;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_s1   <= 3'h0;
      temp_s2   <= 3'h0;
      temp_word <= 3'h0;
      tsi_cnt   <= '0;
      temp_tgl  <= 1'h0;
    end else begin
      temp_s1   <= temp_code;
      temp_s2   <= temp_s1;
      temp_word <= next_temp_word;
      tsi_cnt   <= next_tsi_cnt;
      temp_tgl  <= next_temp_tgl;
    end
  end

  // link domain reset release
  logic [1:0] rst_ck;
  logic       link_rst_n;

  always_ff @(posedge ck or negedge rst_n) begin
    if (!rst_n) begin
      rst_ck <= 2'h0;
    end else begin
      rst_ck <= {rst_ck[0], 1'h1};
    end
  end
  assign link_rst_n = rst_ck[1];

  // command capture on both link edges
  logic       cs_n_r;
  logic [9:0] ca_r;
  logic [9:0] ca_f;

  always_ff @(posedge ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cs_n_r <= 1'h1;
      ca_r   <= 10'h000;
    end else begin
      cs_n_r <= cs_n;
      ca_r   <= ca;
    end
  end

  always_ff @(negedge ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ca_f <= 10'h000;
    end else begin
      ca_f <= ca;
    end
  end

  // decode
  logic                    is_mrr;
  logic                    is_mrw;
  logic                    mrr_go;
  logic                    mrw_go;
  logic                    rst_go;
  logic                    cfg_hit;
  logic [1:0]              cfg_idx;
  logic [7:0]              ma;
  logic [7:0]              wdat;
  logic [7:0]              rd_sel;
  logic                    cal_sel;
  logic [3:0]              pat_sel;
  mra_state_type           state;
  mra_state_type           next_state;
  logic [2:0]              tgl_sync;
  logic [2:0]              temp_link;
  logic [2:0]              next_temp_link;
  logic [mra_pkg::NCFG-1:0][7:0] cfg;
  logic [mra_pkg::NCFG-1:0][7:0] next_cfg;

  assign is_mrr = !cs_n_r && ca_r[3:0] == mra_pkg::CMD_MRR;
  assign is_mrw = !cs_n_r && ca_r[3:0] == mra_pkg::CMD_MRW;
  assign ma = {ca_r[mra_pkg::MA_HI_MSB:mra_pkg::MA_HI_LSB],
               ca_f[mra_pkg::MA_LO_MSB:mra_pkg::MA_LO_LSB]};
  assign wdat    = ca_f[mra_pkg::WD_MSB:mra_pkg::WD_LSB];
  assign mrr_go  = state == ST_IDLE && is_mrr;
  assign mrw_go  = state == ST_IDLE && is_mrw && !bank_active;
  assign rst_go  = mrw_go && ma == mra_pkg::MA_RESET;
  assign cfg_hit = ma >= mra_pkg::MA_CFG_FIRST && ma <= mra_pkg::MA_CFG_LAST;
  assign cfg_idx = 2'(ma - mra_pkg::MA_CFG_FIRST);

  // register read selection
  always_comb begin
    rd_sel  = 8'h00;
    cal_sel = 1'h0;
    pat_sel = 4'h0;
    if (ma == mra_pkg::MA_TEMP) begin
      rd_sel = {5'h00, temp_link};
    end else if (cfg_hit) begin
      rd_sel = cfg[cfg_idx];
    end else if (ma == mra_pkg::MA_CAL_A) begin
      cal_sel = 1'h1;
      pat_sel = mra_pkg::CAL_A_PATTERN;
    end else if (ma == mra_pkg::MA_CAL_B) begin
      cal_sel = 1'h1;
      pat_sel = mra_pkg::CAL_B_PATTERN;
    end
  end

  // read burst, write and reset sequencing
  logic [15:0]         cnt;
  logic [15:0]         next_cnt;
  logic [2:0]          beat;
  logic [2:0]          next_beat;
  logic [7:0]          rd_val;
  logic [7:0]          next_rd_val;
  logic                rd_cal;
  logic                next_rd_cal;
  logic [3:0]          rd_pat;
  logic [3:0]          next_rd_pat;
  logic [DQ_WIDTH-1:0] next_dq_out;
  logic                next_dq_oe_n;
  logic [NDQS-1:0]     next_dqs_out;
  logic                next_dqs_oe_n;
  logic                next_init_busy;

  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_beat      = beat;
    next_rd_val    = rd_val;
    next_rd_cal    = rd_cal;
    next_rd_pat    = rd_pat;
    next_cfg       = cfg;
    next_dq_out    = dq_out;
    next_dq_oe_n   = dq_oe_n;
    next_dqs_out   = dqs_out;
    next_dqs_oe_n  = dqs_oe_n;
    next_init_busy = init_busy;
    next_temp_link = temp_link;
    if (tgl_sync[2] != tgl_sync[1]) begin
      next_temp_link = temp_word;
    end
    unique case (state)
      ST_IDLE: begin
        if (mrr_go) begin
          next_state  = ST_READ;
          next_cnt    = 16'(RL - 2);
          next_beat   = 3'h0;
          next_rd_val = rd_sel;
          next_rd_cal = cal_sel;
          next_rd_pat = pat_sel;
        end else if (rst_go) begin
          next_cfg       = mra_pkg::CFG_RESET;
          next_state     = ST_INIT;
          next_cnt       = 16'(INIT_CYCLES - 1);
          next_init_busy = 1'h1;
        end else if (mrw_go && cfg_hit) begin
          next_cfg[cfg_idx] = wdat;
        end
      end
      ST_READ: begin
        // commands during the read are ignored
        if (cnt != 16'h0000) begin
          next_cnt = cnt - 16'h0001;
        end else if (beat != mra_pkg::BURST_BEATS) begin
          if (rd_cal) begin
            next_dq_out = {DQ_WIDTH{rd_pat[beat[1:0]]}};
          end else if (beat == 3'h0) begin
            next_dq_out = DQ_WIDTH'(rd_val);
          end else begin
            next_dq_out = '0;
          end
          next_dq_oe_n  = 1'h0;
          next_dqs_out  = ~dqs_out;
          next_dqs_oe_n = 1'h0;
          next_beat     = beat + 3'h1;
        end else begin
          next_dq_out   = '0;
          next_dq_oe_n  = 1'h1;
          next_dqs_out  = '0;
          next_dqs_oe_n = 1'h1;
          next_state    = ST_IDLE;
        end
      end
      ST_INIT: begin
        // commands during the wait are ignored
        if (cnt != 16'h0000) begin
          next_cnt = cnt - 16'h0001;
        end else begin
          next_state     = ST_IDLE;
          next_init_busy = 1'h0;
        end
      end
    endcase
  end

  always_ff @(posedge ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state     <= ST_IDLE;
      cnt       <= 16'h0000;
      beat      <= 3'h0;
      rd_val    <= 8'h00;
      rd_cal    <= 1'h0;
      rd_pat    <= 4'h0;
      cfg       <= mra_pkg::CFG_RESET;
      dq_out    <= '0;
      dq_oe_n   <= 1'h1;
      dqs_out   <= '0;
      dqs_oe_n  <= 1'h1;
      init_busy <= 1'h0;
      tgl_sync  <= 3'h0;
      temp_link <= 3'h0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      beat      <= next_beat;
      rd_val    <= next_rd_val;
      rd_cal    <= next_rd_cal;
      rd_pat    <= next_rd_pat;
      cfg       <= next_cfg;
      dq_out    <= next_dq_out;
      dq_oe_n   <= next_dq_oe_n;
      dqs_out   <= next_dqs_out;
      dqs_oe_n  <= next_dqs_oe_n;
      init_busy <= next_init_busy;
      tgl_sync  <= {tgl_sync[1:0], temp_tgl};
      temp_link <= next_temp_link;
    end
  end

  // checks
  default clocking cb @(posedge ck); endclocking
  default disable iff (!link_rst_n);

  sequence s_wait;
    dq_oe_n ##LAT_M1 !dq_oe_n;
  endsequence
  sequence s_burst;
    !dq_oe_n [*4] ##1 dq_oe_n;
  endsequence

  AST_MRR_BURST: assert property (mrr_go |=> s_wait ##0 s_burst)
    else $error("read burst timing wrong");
  AST_DQS_TOGGLE: assert property (!dq_oe_n && !$past(dq_oe_n) |-> dqs_out == ~$past(dqs_out))
    else $error("strobe did not toggle");
  AST_FIRST_BEAT: assert property ($fell(dq_oe_n) && !rd_cal |-> dq_out == DQ_WIDTH'(rd_val))
    else $error("first beat data wrong");
  AST_CAL_COPY: assert property (!dq_oe_n && rd_cal |-> dq_out == {DQ_WIDTH{dq_out[0]}})
    else $error("calibration lines differ");
  AST_CAL_A: assert property ($fell(dq_oe_n) && rd_cal && rd_pat == mra_pkg::CAL_A_PATTERN
      |-> dq_out[0] ##1 !dq_out[0] ##1 dq_out[0] ##1 !dq_out[0])
    else $error("pattern a wrong");
  AST_CAL_B: assert property ($fell(dq_oe_n) && rd_cal && rd_pat == mra_pkg::CAL_B_PATTERN
      |-> !dq_out[0] ##1 !dq_out[0] ##1 dq_out[0] ##1 dq_out[0])
    else $error("pattern b wrong");
  AST_RO_WRITE: assert property (is_mrw && !cfg_hit && ma != mra_pkg::MA_RESET |=> $stable(cfg))
    else $error("read-only write changed state");
  AST_BANK_BLOCK: assert property (is_mrw && bank_active |=> $stable(cfg) && $stable(init_busy))
    else $error("write accepted with bank active");
  AST_RESET_INIT: assert property (rst_go |=> init_busy && cfg == mra_pkg::CFG_RESET
      ##INIT_M init_busy ##1 !init_busy)
    else $error("reset write sequence wrong");
  AST_TEMP_READ: assert property (mrr_go && ma == mra_pkg::MA_TEMP |=> rd_val == {5'h00, $past(temp_link)})
    else $error("temperature value wrong");
  AST_TSI_UPDATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      tsi_cnt == '0 |=> temp_tgl != $past(temp_tgl) && tsi_cnt == TW'(TSI_CYCLES - 1))
    else $error("sensor update missed");

endmodule

/* mra_device_tb.sv */
// testbench of the mode register access block
`timescale 1ns/1ps
module mra_device_tb;
  localparam int DW   = 16;
  localparam int RL   = 3;
  localparam int INIT = 8;
  logic            ref_clk     = 1'b0;
  logic            ck;
  logic            rst_n       = 1'b0;
  logic            bank_active = 1'b0;
  logic [2:0]      temp_code   = 3'h6;
  logic            cs_n;
  logic [9:0]      ca;
  logic [DW-1:0]   dq_out;
  logic            dq_oe_n;
  logic [DW/8-1:0] dqs_out;
  logic            dqs_oe_n;
  logic            init_busy;
  logic [7:0]      dflt [3]    = '{8'h02, 8'h01, 8'h04};
  int              fail_count  = 0;
  int              n_tests     = 0;
  int              cnt;

  always #10 ref_clk = ~ref_clk;
  initial begin
    ck = 1'b0;
    #7;
    forever #15 ck = ~ck;
  end

  mra_ctl_model ctl (.ck(ck), .cs_n(cs_n), .ca(ca));

  mra_device #(.DQ_WIDTH(DW), .RL(RL), .TSI_CYCLES(50), .INIT_CYCLES(INIT)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ck(ck), .cs_n(cs_n), .ca(ca),
    .bank_active(bank_active), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n), .temp_code(temp_code),
    .init_busy(init_busy)
  );

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // register read with beat by beat compare
  task automatic rd(input logic [7:0] ma, input logic [7:0] v, input logic cal, input logic [3:0] pat);
    logic [DW-1:0] e;
    ctl.cmd(mra_pkg::CMD_MRR, ma, 8'h00);
    repeat (RL) @(posedge ck);
    for (int n = 0; n < 4; n++) begin
      e = cal ? {DW{pat[n]}} : ((n == 0) ? DW'(v) : '0);
      @(negedge ck);
      chk(dq_oe_n === 1'b0 && dqs_oe_n === 1'b0, "data enable");
      chk(dqs_out === {(DW/8){~n[0]}}, "strobe");
      chk(dq_out === e, "read data");
      @(posedge ck);
    end
    @(negedge ck);
    chk(dq_oe_n === 1'b1 && dqs_oe_n === 1'b1, "burst end");
  endtask

  initial begin
    #100us;
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge ck);
    for (int i = 0; i < 3; i++) rd(8'h01 + 8'(i), dflt[i], 1'b0, 4'h0);
    // the first sensor sample after reset still holds the reset code
    repeat (60) @(posedge ref_clk);
    repeat (6) @(posedge ck);
    rd(mra_pkg::MA_TEMP, 8'h06, 1'b0, 4'h0);
    ctl.cmd(mra_pkg::CMD_MRW, 8'h01, 8'hA5);
    ctl.cmd(mra_pkg::CMD_MRW, 8'h03, 8'h3C);
    ctl.cmd(mra_pkg::CMD_MRW, mra_pkg::MA_CAL_A, 8'hFF);
    ctl.cmd(mra_pkg::CMD_MRW, mra_pkg::MA_TEMP, 8'hFF);
    rd(8'h01, 8'hA5, 1'b0, 4'h0);
    rd(8'h03, 8'h3C, 1'b0, 4'h0);
    rd(mra_pkg::MA_CAL_A, 8'h00, 1'b1, 4'h5);
    rd(mra_pkg::MA_CAL_B, 8'h00, 1'b1, 4'hC);
    @(posedge ref_clk);
    temp_code <= 3'h3;
    repeat (60) @(posedge ref_clk);
    repeat (6) @(posedge ck);
    rd(mra_pkg::MA_TEMP, 8'h03, 1'b0, 4'h0);
    @(posedge ck);
    bank_active <= 1'b1;
    ctl.cmd(mra_pkg::CMD_MRW, 8'h02, 8'h77);
    rd(8'h02, 8'h01, 1'b0, 4'h0);
    @(posedge ck);
    bank_active <= 1'b0;
    ctl.cmd(mra_pkg::CMD_MRW, mra_pkg::MA_RESET, 8'h00);
    cnt = 0;
    repeat (INIT + 6) begin
      @(negedge ck);
      if (init_busy === 1'b1) cnt++;
    end
    chk(cnt == INIT, "init length");
    for (int i = 0; i < 3; i++) rd(8'h01 + 8'(i), dflt[i], 1'b0, 4'h0);
    complete_run();
  end
endmodule

/* mra_pkg.sv */
// constants of the mode register access block
package mra_pkg;

  // command codes on ca[3:0] at the rising edge
  localparam logic [3:0] CMD_MRR = 4'h8;
  localparam logic [3:0] CMD_MRW = 4'h0;

  // mode register addresses
  localparam logic [7:0] MA_CFG_FIRST = 8'h01;
  localparam logic [7:0] MA_CFG_LAST  = 8'h03;
  localparam logic [7:0] MA_TEMP      = 8'h04;
  localparam logic [7:0] MA_CAL_A     = 8'h20;
  localparam logic [7:0] MA_CAL_B     = 8'h28;
  localparam logic [7:0] MA_RESET     = 8'h3F;

  // address and data field positions
  localparam int MA_HI_MSB = 9;
  localparam int MA_HI_LSB = 4;
  localparam int MA_LO_MSB = 1;
  localparam int MA_LO_LSB = 0;
  localparam int WD_MSB    = 9;
  localparam int WD_LSB    = 2;

  // writable registers and their reset values
  localparam int NCFG = 3;
  localparam logic [NCFG-1:0][7:0] CFG_RESET = {8'h04, 8'h01, 8'h02};

  // calibration patterns, bit n is beat n
  localparam logic [3:0] CAL_A_PATTERN = 4'h5;
  localparam logic [3:0] CAL_B_PATTERN = 4'hC;

  // burst and timing
  localparam logic [2:0] BURST_BEATS = 3'h4;
  localparam int TSI_MS       = 16;
  localparam int REF_CLK_KHZ  = 50000;
  localparam int TSI_CYCLES   = TSI_MS * REF_CLK_KHZ;
  localparam int INIT_CYCLES  = 16;

endpackage
